// *** core/lcc_cycle_ctl.sv ***
// lcc_cycle_ctl: cycle control of a two-way writeback second-level cache
// assumes: bus controller drives progress handshakes on MCLK
`timescale 1ns/100ps
module lcc_cycle_ctl #(
    parameter int SETS  = lcc_pkg::SETS_DEF,
    parameter int TAG_W = lcc_pkg::TAG_W_DEF
) (
    // clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET_N,
    // configuration
    input  wire logic                  LINE_EIGHT,
    input  wire logic                  FREEZE_EN,
    // cpu request
    input  wire lcc_pkg::lcc_cpu_req_t CPU_REQ,
    input  wire logic                  CPU_INQ_DONE,
    output logic                       CPU_INQ,
    output logic                       CPU_ADDR_HOLD,
    // snoop request
    input  wire logic                  SNOOP_REQ,
    input  wire logic [3:0]            SNOOP_SET,
    input  wire logic [7:0]            SNOOP_TAG,
    input  wire logic                  SNOOP_INV,
    // flush and sync
    input  wire logic                  FLUSH_N,
    input  wire logic                  SYNC_N,
    output logic                       FLUSH_SYNC_STATUS_N,
    // bus controller progress
    input  wire lcc_pkg::lcc_bus_prog_t BUS_PROG,
    // memory bus cycle outputs
    output logic                       CYCLE_ADDR_STROBE_N,
    output logic                       MEM_WRITE,
    output logic                       MEM_CACHEABLE_N,
    output logic [3:0]                 MEM_LENGTH,
    output logic                       SNOOP_HIT_MODIFIED_N,
    output logic                       SNOOP_WB_ADDR_STROBE_N,
    output logic                       DATA_TRANSFER_START_N,
    output logic                       LOCKED_CYCLE_OUT_N,
    output logic                       SPLIT_CYCLE_OUT,
    output logic                       WRITE_FREEZE_N,
    output logic                       CPU_FROM_ARRAY,
    output logic                       VICTIM_IN_BUFFER
);
    initial begin
        if (SETS != 16 || TAG_W != 8)
            $error("lcc_cycle_ctl: SETS must be 16 and TAG_W 8");
    end

    lcc_pkg::lcc_state_t st_ff, nxt_st;
    lcc_pkg::lcc_mesi_t  mesi_ff [SETS][2];
    logic [TAG_W-1:0]    tag_ff  [SETS][2];
    logic [SETS-1:0]     lru_ff;
    logic [3:0]          set_ff, nxt_set;
    logic                way_ff, nxt_way;
    logic [3:0]          cnt_ff, nxt_cnt;
    logic                lock_gap_ff;
    logic                wb_busy_ff;
    logic [7:0]          vic_tag_ff;
    logic [3:0]          vic_set_ff;
    logic                snp_way_ff;
    logic                sync_ff;
    logic                walk_ff;
    logic                snp_hit_d_ff;

    // a line is 4 or 8 transfers
    wire [3:0] line_len = LINE_EIGHT ? 4'(lcc_pkg::XFER_LONG)
                                     : 4'(lcc_pkg::XFER_SHORT);
    wire       ready    = !BUS_PROG.ready_n;
    wire       brdy     = !BUS_PROG.brdy_n;
    wire [3:0] cset     = CPU_REQ.set;
    wire       pick_way;
    wire       set_full;
    wire       hit0     = mesi_ff[cset][0] != lcc_pkg::LCC_ST_I
                          && tag_ff[cset][0] == CPU_REQ.tag;
    wire       hit1     = mesi_ff[cset][1] != lcc_pkg::LCC_ST_I
                          && tag_ff[cset][1] == CPU_REQ.tag;
    wire       cpu_hit  = hit0 | hit1;
    wire       hit_way  = hit1;
    wire       shit0    = mesi_ff[SNOOP_SET][0] == lcc_pkg::LCC_ST_M
                          && tag_ff[SNOOP_SET][0] == SNOOP_TAG;
    wire       shit1    = mesi_ff[SNOOP_SET][1] == lcc_pkg::LCC_ST_M
                          && tag_ff[SNOOP_SET][1] == SNOOP_TAG;
    // victim still held in writeback buffer is snoopable
    wire       shit_buf = wb_busy_ff && vic_set_ff == SNOOP_SET
                          && vic_tag_ff == SNOOP_TAG;
    wire       snp_hitm = shit0 | shit1 | shit_buf;
    wire       vic_mod  = mesi_ff[set_ff][way_ff] == lcc_pkg::LCC_ST_M;
    wire       fl_mod   = mesi_ff[set_ff][way_ff] == lcc_pkg::LCC_ST_M;
    wire       fl_last  = set_ff == 4'(SETS-1) && way_ff;
    wire       cpu_lock = CPU_REQ.req && CPU_REQ.lock;
    wire       fill_done = ready || !BUS_PROG.next_addr_n;

    lcc_way_pick u_pick (
        .v0   (mesi_ff[cset][0] != lcc_pkg::LCC_ST_I),
        .v1   (mesi_ff[cset][1] != lcc_pkg::LCC_ST_I),
        .lru  (lru_ff[cset]),
        .way  (pick_way),
        .full (set_full)
    );

    always_comb begin
        nxt_st  = st_ff;
        nxt_set = set_ff;
        nxt_way = way_ff;
        nxt_cnt = cnt_ff;
        unique case (st_ff)
            lcc_pkg::LCC_IDLE: begin
                if (SNOOP_REQ && snp_hitm) begin
                    nxt_st = lcc_pkg::LCC_SNP_HIT;
                end else if (!FLUSH_N || !SYNC_N) begin
                    nxt_st  = lcc_pkg::LCC_FLUSH;
                    nxt_set = 4'h0;
                    nxt_way = 1'b0;
                    nxt_cnt = 4'h0;
                end else if (wb_busy_ff) begin
                    nxt_st = lcc_pkg::LCC_RPL_ADS;
                end else if (CPU_REQ.req && (CPU_REQ.io || CPU_REQ.special))
                begin
                    nxt_st = lcc_pkg::LCC_IO;
                end else if (cpu_lock && !lock_gap_ff) begin
                    nxt_st = lcc_pkg::LCC_LOCKED;
                end else if (CPU_REQ.req && CPU_REQ.write && !cpu_hit
                             && FREEZE_EN) begin
                    nxt_st = lcc_pkg::LCC_FRZ;
                end else if (CPU_REQ.req && !cpu_hit && !CPU_REQ.write
                             && !CPU_REQ.lock) begin
                    nxt_st  = lcc_pkg::LCC_FILL;
                    nxt_set = cset;
                    nxt_way = pick_way;
                end
            end
            lcc_pkg::LCC_FILL:
                if (fill_done)
                    nxt_st = (set_full && vic_mod) ? lcc_pkg::LCC_RPL_INQ
                                                   : lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_RPL_INQ:
                if (CPU_INQ_DONE)
                    nxt_st = lcc_pkg::LCC_RPL_ADS;
            lcc_pkg::LCC_RPL_ADS: begin
                nxt_st  = lcc_pkg::LCC_RPL_DAT;
                nxt_cnt = 4'h0;
            end
            lcc_pkg::LCC_RPL_DAT:
                if (ready)
                    nxt_st = walk_ff ? lcc_pkg::LCC_FL_WB
                                     : lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_SNP_HIT:
                nxt_st = lcc_pkg::LCC_SNP_INQ;
            lcc_pkg::LCC_SNP_INQ:
                if (CPU_INQ_DONE)
                    nxt_st = lcc_pkg::LCC_SNP_DAT;
            lcc_pkg::LCC_SNP_DAT:
                if (ready)
                    nxt_st = lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_LOCKED:
                if (!cpu_lock)
                    nxt_st = lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_IO:
                if (ready)
                    nxt_st = lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_FRZ:
                if (ready)
                    nxt_st = lcc_pkg::LCC_IDLE;
            lcc_pkg::LCC_FLUSH: begin
                // each tag lookup in the flush or sync walk takes two clocks
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == 4'(lcc_pkg::TAG_LOOK_CLK - 1)) begin
                    nxt_cnt = 4'h0;
                    if (fl_mod || (mesi_ff[set_ff][way_ff]
                                   != lcc_pkg::LCC_ST_I && !sync_ff))
                        nxt_st = lcc_pkg::LCC_FL_INQ;
                    else
                        nxt_st = lcc_pkg::LCC_FL_WB;
                end
            end
            lcc_pkg::LCC_FL_INQ:
                if (CPU_INQ_DONE)
                    nxt_st = fl_mod ? lcc_pkg::LCC_RPL_ADS
                                    : lcc_pkg::LCC_FL_WB;
            lcc_pkg::LCC_FL_WB: begin
                nxt_st = fl_last ? lcc_pkg::LCC_IDLE : lcc_pkg::LCC_FLUSH;
                {nxt_set, nxt_way} = 5'({set_ff, way_ff} + 5'h01);
            end
            default:
                nxt_st = lcc_pkg::LCC_IDLE;
        endcase
    end

    wire in_rpl = st_ff == lcc_pkg::LCC_RPL_ADS
                  || st_ff == lcc_pkg::LCC_RPL_DAT;
    wire in_snp = st_ff == lcc_pkg::LCC_SNP_DAT;
    wire leaving_fill = st_ff == lcc_pkg::LCC_FILL && fill_done;

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            st_ff       <= lcc_pkg::LCC_IDLE;
            set_ff      <= 4'h0;
            way_ff      <= 1'b0;
            cnt_ff      <= 4'h0;
            lru_ff      <= '0;
            lock_gap_ff <= 1'b0;
            wb_busy_ff  <= 1'b0;
            vic_tag_ff  <= 8'h00;
            vic_set_ff  <= 4'h0;
            snp_way_ff  <= 1'b0;
            sync_ff     <= 1'b0;
            walk_ff     <= 1'b0;
            snp_hit_d_ff <= 1'b0;
            for (int s = 0; s < SETS; s++) begin
                for (int w = 0; w < 2; w++) begin
                    mesi_ff[s][w] <= lcc_pkg::LCC_ST_I;
                    tag_ff[s][w]  <= 8'h00;
                end
            end
        end else begin
            st_ff  <= nxt_st;
            set_ff <= nxt_set;
            way_ff <= nxt_way;
            cnt_ff <= nxt_cnt;
            snp_hit_d_ff <= st_ff == lcc_pkg::LCC_SNP_HIT;
            // walk flag spans writebacks inside a flush or sync
            if (st_ff == lcc_pkg::LCC_IDLE && nxt_st == lcc_pkg::LCC_FLUSH)
                walk_ff <= 1'b1;
            else if (st_ff == lcc_pkg::LCC_FL_WB && fl_last)
                walk_ff <= 1'b0;
            // one idle clock after each locked sequence
            lock_gap_ff <= st_ff == lcc_pkg::LCC_LOCKED && !cpu_lock;
            if (st_ff == lcc_pkg::LCC_IDLE && (!FLUSH_N || !SYNC_N))
                sync_ff <= FLUSH_N;
            if (st_ff == lcc_pkg::LCC_IDLE && SNOOP_REQ)
                snp_way_ff <= shit1;
            // tags: locked cycles never reach here
            if (CPU_REQ.req && cpu_hit && !CPU_REQ.lock
                && st_ff == lcc_pkg::LCC_IDLE) begin
                lru_ff[cset] <= !hit_way;
                if (CPU_REQ.write && mesi_ff[cset][hit_way]
                    == lcc_pkg::LCC_ST_E)
                    mesi_ff[cset][hit_way] <= lcc_pkg::LCC_ST_M;
            end
            if (leaving_fill) begin
                // victim moves to writeback buffer
                if (set_full && vic_mod) begin
                    wb_busy_ff <= 1'b1;
                    vic_tag_ff <= tag_ff[set_ff][way_ff];
                    vic_set_ff <= set_ff;
                end
                tag_ff[set_ff][way_ff] <= CPU_REQ.tag;
                lru_ff[set_ff]         <= !way_ff;
                // modified on direct-to-modified, else shared when select is low, else exclusive
                if (!BUS_PROG.direct_to_modified_n)
                    mesi_ff[set_ff][way_ff] <= lcc_pkg::LCC_ST_M;
                else if (!BUS_PROG.wb_or_wt_select)
                    mesi_ff[set_ff][way_ff] <= lcc_pkg::LCC_ST_S;
                else
                    mesi_ff[set_ff][way_ff] <= lcc_pkg::LCC_ST_E;
            end
            if (st_ff == lcc_pkg::LCC_RPL_DAT && ready)
                wb_busy_ff <= 1'b0;
            if (st_ff == lcc_pkg::LCC_SNP_HIT) begin
                if (shit_buf && !(shit0 | shit1))
                    wb_busy_ff <= 1'b0;
                else
                    mesi_ff[SNOOP_SET][snp_way_ff] <= SNOOP_INV
                        ? lcc_pkg::LCC_ST_I : lcc_pkg::LCC_ST_S;
            end
            if (st_ff == lcc_pkg::LCC_FL_WB && !sync_ff)
                mesi_ff[set_ff][way_ff] <= lcc_pkg::LCC_ST_I;
            if (st_ff == lcc_pkg::LCC_FL_INQ && CPU_INQ_DONE && fl_mod) begin
                wb_busy_ff <= 1'b1;
                vic_tag_ff <= tag_ff[set_ff][way_ff];
                vic_set_ff <= set_ff;
                if (sync_ff)
                    mesi_ff[set_ff][way_ff] <= lcc_pkg::LCC_ST_E;
            end
        end
    end

    wire ads_io  = st_ff == lcc_pkg::LCC_IDLE && nxt_st == lcc_pkg::LCC_IO;
    wire ads_lk  = st_ff == lcc_pkg::LCC_IDLE
                   && nxt_st == lcc_pkg::LCC_LOCKED;
    wire ads_frz = st_ff == lcc_pkg::LCC_IDLE && nxt_st == lcc_pkg::LCC_FRZ;
    wire ads_fil = st_ff == lcc_pkg::LCC_IDLE
                   && nxt_st == lcc_pkg::LCC_FILL;

    assign CYCLE_ADDR_STROBE_N = !(st_ff == lcc_pkg::LCC_RPL_ADS
                                   || ads_io || ads_lk || ads_frz
                                   || ads_fil);
    assign MEM_WRITE        = in_rpl || in_snp || ads_frz
                              || (ads_lk && CPU_REQ.write);
    assign MEM_CACHEABLE_N  = !in_rpl;
    assign MEM_LENGTH       = (ads_io || ads_lk) ? 4'h1 : line_len;
    assign SNOOP_HIT_MODIFIED_N  = !(st_ff == lcc_pkg::LCC_SNP_HIT
                                     || st_ff == lcc_pkg::LCC_SNP_INQ);
    assign SNOOP_WB_ADDR_STROBE_N = !(st_ff == lcc_pkg::LCC_SNP_INQ
                                      && snp_hit_d_ff);
    assign DATA_TRANSFER_START_N  = !(st_ff == lcc_pkg::LCC_SNP_DAT
                                      && cnt_ff == 4'h0);
    assign CPU_INQ = st_ff == lcc_pkg::LCC_RPL_INQ
                     || st_ff == lcc_pkg::LCC_SNP_INQ
                     || st_ff == lcc_pkg::LCC_FL_INQ;
    assign LOCKED_CYCLE_OUT_N = !(cpu_lock && !lock_gap_ff);
    assign SPLIT_CYCLE_OUT    = cpu_lock && CPU_REQ.split
                                && !lock_gap_ff;
    assign WRITE_FREEZE_N     = !(st_ff == lcc_pkg::LCC_FRZ);
    assign CPU_FROM_ARRAY     = st_ff == lcc_pkg::LCC_LOCKED && cpu_hit
                                && mesi_ff[cset][hit_way]
                                   == lcc_pkg::LCC_ST_M && brdy;
    assign CPU_ADDR_HOLD      = walk_ff;
    assign FLUSH_SYNC_STATUS_N = !CPU_ADDR_HOLD;
    assign VICTIM_IN_BUFFER    = wb_busy_ff;

    property p_snp_order;
        @(posedge MCLK) disable iff (!RESET_N)
        !SNOOP_WB_ADDR_STROBE_N |-> $past(!SNOOP_HIT_MODIFIED_N);
    endproperty
    a_snp_order: assert property (p_snp_order)
        else $error("snoop strobe without prior hit-modified");

    property p_dts_after_inq;
        @(posedge MCLK) disable iff (!RESET_N)
        $fell(DATA_TRANSFER_START_N) |-> $past(CPU_INQ_DONE) && !CPU_INQ;
    endproperty
    a_dts_after_inq: assert property (p_dts_after_inq)
        else $error("transfer start during inquire");

    property p_split;
        @(posedge MCLK) disable iff (!RESET_N)
        SPLIT_CYCLE_OUT |-> !LOCKED_CYCLE_OUT_N && CPU_REQ.split;
    endproperty
    a_split: assert property (p_split)
        else $error("split output outside locked split");

    property p_lock_gap;
        @(posedge MCLK) disable iff (!RESET_N)
        $past(st_ff) == lcc_pkg::LCC_LOCKED && st_ff != lcc_pkg::LCC_LOCKED
        |-> LOCKED_CYCLE_OUT_N;
    endproperty
    a_lock_gap: assert property (p_lock_gap)
        else $error("lock not dropped between sequences");

    property p_rpl_cache;
        @(posedge MCLK) disable iff (!RESET_N)
        st_ff == lcc_pkg::LCC_RPL_ADS |->
            !CYCLE_ADDR_STROBE_N && !MEM_CACHEABLE_N && MEM_WRITE;
    endproperty
    a_rpl_cache: assert property (p_rpl_cache)
        else $error("replacement write not flagged cacheable");

    property p_io_len;
        @(posedge MCLK) disable iff (!RESET_N)
        ads_io |-> MEM_LENGTH == 4'h1;
    endproperty
    a_io_len: assert property (p_io_len)
        else $error("i/o cycle length not one");

    property p_rpl_inq;
        @(posedge MCLK) disable iff (!RESET_N)
        leaving_fill && set_full && vic_mod |=> CPU_INQ;
    endproperty
    a_rpl_inq: assert property (p_rpl_inq)
        else $error("no inquire for expelled modified line");

    property p_flush_look;
        @(posedge MCLK) disable iff (!RESET_N)
        $rose(st_ff == lcc_pkg::LCC_FLUSH) |=>
            st_ff == lcc_pkg::LCC_FLUSH;
    endproperty
    a_flush_look: assert property (p_flush_look)
        else $error("tag lookup shorter than two clocks");
endmodule // lcc_cycle_ctl

// *** core/lcc_pkg.sv ***
// lcc_pkg: shared constants and carrier types for the cycle-control core
// assumes: single clock domain, all pins active as named
package lcc_pkg;
    localparam int SETS_DEF     = 16;
    localparam int XFER_SHORT   = 4;
    localparam int XFER_LONG    = 8;
    localparam int TAG_LOOK_CLK = 2;
    localparam int TAG_W_DEF    = 8;

    typedef enum logic [1:0] {
        LCC_ST_I = 2'h0,
        LCC_ST_S = 2'h1,
        LCC_ST_E = 2'h2,
        LCC_ST_M = 2'h3
    } lcc_mesi_t;

    typedef enum logic [3:0] {
        LCC_IDLE     = 4'h0,
        LCC_FILL     = 4'h1,
        LCC_RPL_INQ  = 4'h2,
        LCC_RPL_ADS  = 4'h3,
        LCC_RPL_DAT  = 4'h4,
        LCC_SNP_HIT  = 4'h5,
        LCC_SNP_INQ  = 4'h6,
        LCC_SNP_DAT  = 4'h7,
        LCC_LOCKED   = 4'h8,
        LCC_IO       = 4'h9,
        LCC_FRZ      = 4'hA,
        LCC_FLUSH    = 4'hB,
        LCC_FL_INQ   = 4'hC,
        LCC_FL_WB    = 4'hD
    } lcc_state_t;

    typedef struct packed {
        logic       req;
        logic       write;
        logic       io;
        logic       special;
        logic       lock;
        logic       split;
        logic [3:0] set;
        logic [7:0] tag;
    } lcc_cpu_req_t;

    typedef struct packed {
        logic       ready_n;
        logic       next_addr_n;
        logic       brdy_n;
        logic       write_end_n;
        logic       snoop_write_end_n;
        logic       wb_or_wt_select;
        logic       direct_to_modified_n;
    } lcc_bus_prog_t;
endpackage

// *** core/lcc_way_pick.sv ***
// lcc_way_pick: per-set victim choice from valid bits and an lru bit
// assumes: caller holds the lru table
`timescale 1ns/100ps
module lcc_way_pick (
    // state of the set
    input  wire logic         v0,
    input  wire logic         v1,
    input  wire logic         lru,
    // choice
    output logic              way,
    output logic              full
);
    assign full = v0 & v1;
    // free way first, else least recently used
    assign way  = !v0 ? 1'b0 : (!v1 ? 1'b1 : lru);
endmodule // lcc_way_pick

// *** bench/lcc_bus_model.sv ***
// lcc_bus_model: memory bus controller and cpu inquire responder
// assumes: replies dly clocks after a strobe, drives just after MCLK rises
`timescale 1ns/100ps
module lcc_bus_model (
    // clock, reset, setup
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              dtm,
    input  wire logic [1:0]        dly,
    // from the core
    input  wire logic              stb_n,
    input  wire logic              snp_stb_n,
    input  wire logic              xfer_n,
    input  wire logic              inq,
    // to the core
    output lcc_pkg::lcc_bus_prog_t prog,
    output logic                   inq_done
);
    logic rdy_n = 1'b1;
    logic busy, snp, s, ss, x, i, rs;
    int   cnt, icnt;
    // ready, brdy and write-end strobes complete together, next address stays high; owner goes modified when dtm
    assign prog = '{rdy_n, 1'b1, rdy_n, rdy_n, rdy_n, 1'b1,
                    rdy_n | ~dtm};
    initial inq_done = 1'b0;
    always @(posedge clk) begin
        {s, ss, x, i, rs} = {stb_n, snp_stb_n, xfer_n, inq, rst_n};
        #1;
        rdy_n = 1'b1;
        inq_done = 1'b0;
        if (!rs) begin
            busy = 1'b0;
            icnt = 0;
        end else begin
            if (!s || !ss) begin
                busy = 1'b1;
                snp = !ss;
                cnt = 0;
            // snoop writeback data only after transfer start
            end else if (busy && (!snp || !x)) begin
                cnt++;
                if (cnt >= dly) begin
                    rdy_n = 1'b0;
                    busy = 1'b0;
                end
            end
            icnt = i ? icnt + 1 : 0;
            if (icnt > dly) begin
                inq_done = 1'b1;
                icnt = 0;
            end
        end
    end
endmodule // lcc_bus_model

// *** bench/testbench.sv ***
// testbench: drives the cycle-control core against a bus controller model
// assumes: core and bus model compiled first
`timescale 1ns/100ps
module testbench;
    logic MCLK = 1'b0, RESET_N = 1'b0, LINE_EIGHT, SNOOP_REQ, SNOOP_INV;
    logic FLUSH_N, CPU_INQ_DONE, CPU_INQ, CPU_ADDR_HOLD, FLUSH_SYNC_STATUS_N;
    logic CYCLE_ADDR_STROBE_N, MEM_WRITE, MEM_CACHEABLE_N, DTS_N, HITM_N;
    logic SNP_STB_N, LOCKED_CYCLE_OUT_N, SPLIT_CYCLE_OUT;
    logic SYNC_N, FREEZE_EN, WRITE_FREEZE_N, CPU_FROM_ARRAY, VICTIM_IN_BUFFER;
    logic [1:0] dly;
    logic [3:0] SNOOP_SET, MEM_LENGTH, ln, s;
    logic [7:0] SNOOP_TAG, tg;
    logic [7:0] exp_q[$];
    lcc_pkg::lcc_cpu_req_t  CPU_REQ, r;
    lcc_pkg::lcc_bus_prog_t BUS_PROG;
    int n_errors = 0, check_count = 0, k;
    always #4 MCLK = ~MCLK;
    lcc_cycle_ctl dut (.MCLK(MCLK), .RESET_N(RESET_N),
        .LINE_EIGHT(LINE_EIGHT), .FREEZE_EN(FREEZE_EN), .CPU_REQ(CPU_REQ),
        .CPU_INQ_DONE(CPU_INQ_DONE), .CPU_INQ(CPU_INQ),
        .CPU_ADDR_HOLD(CPU_ADDR_HOLD), .SNOOP_REQ(SNOOP_REQ),
        .SNOOP_SET(SNOOP_SET), .SNOOP_TAG(SNOOP_TAG), .SNOOP_INV(SNOOP_INV),
        .FLUSH_N(FLUSH_N), .SYNC_N(SYNC_N),
        .FLUSH_SYNC_STATUS_N(FLUSH_SYNC_STATUS_N), .BUS_PROG(BUS_PROG),
        .CYCLE_ADDR_STROBE_N(CYCLE_ADDR_STROBE_N), .MEM_WRITE(MEM_WRITE),
        .MEM_CACHEABLE_N(MEM_CACHEABLE_N), .MEM_LENGTH(MEM_LENGTH),
        .SNOOP_HIT_MODIFIED_N(HITM_N), .SNOOP_WB_ADDR_STROBE_N(SNP_STB_N),
        .DATA_TRANSFER_START_N(DTS_N), .LOCKED_CYCLE_OUT_N(LOCKED_CYCLE_OUT_N),
        .SPLIT_CYCLE_OUT(SPLIT_CYCLE_OUT), .WRITE_FREEZE_N(WRITE_FREEZE_N),
        .CPU_FROM_ARRAY(CPU_FROM_ARRAY), .VICTIM_IN_BUFFER(VICTIM_IN_BUFFER));
    lcc_bus_model bus (.clk(MCLK), .rst_n(RESET_N), .dtm(1'b1), .dly(dly),
        .stb_n(CYCLE_ADDR_STROBE_N), .snp_stb_n(SNP_STB_N), .xfer_n(DTS_N),
        .inq(CPU_INQ), .prog(BUS_PROG), .inq_done(CPU_INQ_DONE));
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded wait for one of the core's handshakes, then step off the edge
    task wait_for(input int w);
        int t;
        logic [8:0] hit;
        for (t = 0; t < 2000; t++) begin
            @(posedge MCLK);
            hit = {!CPU_FROM_ARRAY, WRITE_FREEZE_N, DTS_N, SNP_STB_N, HITM_N,
                   !CPU_INQ, !FLUSH_SYNC_STATUS_N, FLUSH_SYNC_STATUS_N,
                   BUS_PROG.ready_n};
            if (hit[w] === 1'b0)
                break;
        end
        if (t == 2000) begin
            chk("wait", 8'(w), 8'hFF);
            stop_test;
        end
        #1;
    endtask
    task cpu_cycle(input lcc_pkg::lcc_cpu_req_t q);
        CPU_REQ = q;
        wait_for(0);
        CPU_REQ = '0;
        @(posedge MCLK);
        #1;
    endtask
    always @(posedge MCLK) begin
        if (RESET_N && CPU_INQ === 1'b1)
            chk("xfer_start", 8'h01, {7'h00, DTS_N});
        if (RESET_N && CYCLE_ADDR_STROBE_N === 1'b0) begin
            if (exp_q.size() == 0)
                chk("extra_cycle", 8'h00, 8'hFF);
            else
                chk("cycle", exp_q.pop_front(), {MEM_WRITE, MEM_CACHEABLE_N,
                    LOCKED_CYCLE_OUT_N, SPLIT_CYCLE_OUT, MEM_LENGTH});
        end
    end
    initial begin
        void'($urandom(76));
        {SNOOP_REQ, SNOOP_INV, SNOOP_SET, SNOOP_TAG, CPU_REQ} = '0;
        {FLUSH_N, SYNC_N, FREEZE_EN} = 3'h7;
        LINE_EIGHT = 1'($urandom);
        dly = 2'($urandom_range(3, 1));
        ln = LINE_EIGHT ? 4'h8 : 4'h4;
        repeat (4) @(posedge MCLK);
        #1;
        RESET_N = 1'b1;
        chk("idle", 8'h07, {5'h00, CYCLE_ADDR_STROBE_N, SNP_STB_N,
            FLUSH_SYNC_STATUS_N});
        FLUSH_N = 1'b0;
        wait_for(1);
        chk("addr_hold", 8'h01, {7'h00, CPU_ADDR_HOLD});
        FLUSH_N = 1'b1;
        wait_for(2);
        // io, special, then two locked cycles back to back
        for (k = 0; k < 4; k++) begin
            r = '0;
            {r.req, r.io, r.special, r.lock, r.split} = {1'b1, k == 0, k == 1,
                k > 1, k == 3};
            {r.set, r.tag} = 12'($urandom);
            exp_q.push_back({2'h1, ~r.lock, r.split, 4'h1});
            CPU_REQ = r;
            @(posedge MCLK);
            chk("lock_gap", {7'h00, k != 2},
                {7'h00, LOCKED_CYCLE_OUT_N});
            wait_for(0);
            CPU_REQ = '0;
            @(posedge MCLK);
            #1;
        end
        // three misses to one set; the third evicts a modified way
        {s, tg} = 12'($urandom);
        for (k = 0; k < 3; k++) begin
            r = '0;
            {r.req, r.set, r.tag} = {1'b1, s, tg ^ 8'(k)};
            exp_q.push_back({4'h6, ln});
            if (k == 2)
                exp_q.push_back({4'hA, ln});
            cpu_cycle(r);
        end
        wait_for(3);
        chk("victim_buf", 8'h01, {7'h00, VICTIM_IN_BUFFER});
        wait_for(0);
        chk("victim_buf", 8'h00, {7'h00, VICTIM_IN_BUFFER});
        // snoop the surviving modified way
        {SNOOP_SET, SNOOP_TAG, SNOOP_INV, SNOOP_REQ} = {s, tg ^ 8'h01, 2'h3};
        @(posedge MCLK);
        #1;
        SNOOP_REQ = 1'b0;
        wait_for(4);
        wait_for(5);
        chk("hitm_at_strobe", 8'h00, {7'h00, HITM_N});
        wait_for(6);
        wait_for(0);
        // locked read hit to the modified way, served from the array
        r = '0;
        {r.req, r.lock, r.set, r.tag} = {2'h3, s, tg ^ 8'h02};
        exp_q.push_back(8'h41);
        CPU_REQ = r;
        wait_for(8);
        CPU_REQ = '0;
        // sync writes the surviving modified line back
        exp_q.push_back({4'hA, ln});
        SYNC_N = 1'b0;
        wait_for(1);
        SYNC_N = 1'b1;
        wait_for(2);
        // frozen write miss
        r = '0;
        {r.req, r.write, r.set, r.tag} = {2'h3, s, tg ^ 8'h03};
        exp_q.push_back({4'hE, ln});
        CPU_REQ = r;
        wait_for(7);
        wait_for(0);
        CPU_REQ = '0;
        chk("pending", 8'h00, 8'(exp_q.size()));
        stop_test;
    end
endmodule // testbench
